// File: hprp_defines.vh
// Purpose: Constants for the host read port
// Assumes: 250 MHz core clock, 16-bit host data bus
// Notes:   Definitions only
`ifndef HPRP_DEFINES_VH
`define HPRP_DEFINES_VH

// Word and address widths
`define HPRP_DATA_W        16
`define HPRP_ADDR_W        8
`define HPRP_CNT_W         32
// Address fields
`define HPRP_ADDR_LO       1
`define HPRP_ADDR_HI       7
`define HPRP_LANE_HI       2
// Word offsets (address bits 7:1) of the read targets
`define HPRP_OFS_RXDATA    7'h00
`define HPRP_OFS_RXSTS     7'h20
`define HPRP_OFS_TXSTS     7'h24
`define HPRP_OFS_BYTETEST  7'h32
`define HPRP_OFS_RXLEVEL   7'h3e
`define HPRP_OFS_TXLEVEL   7'h40
`define HPRP_OFS_DROP_LO   7'h50
`define HPRP_OFS_DROP_HI   7'h51
// Fixed pattern of the side-effect-free test register
`define HPRP_BYTETEST_VAL  16'h4321
// Value of an unmapped location
`define HPRP_UNMAPPED_VAL  16'h0000
// Target selector codes
`define HPRP_TGT_CSR       2'h0
`define HPRP_TGT_RXDATA    2'h1
`define HPRP_TGT_RXSTS     2'h2
`define HPRP_TGT_TXSTS     2'h3
// Host gap figures, in ns, and the dummy-read cycle time
`define HPRP_GAP_LEVEL_NS  135
`define HPRP_GAP_DROP_NS   180
`define HPRP_TCYCLE_NS     45
`define HPRP_CLK_NS        4
// Most words in a normal burst
`define HPRP_BURST_MAX     16

`endif

// File: hprp_edge.v
// Purpose: Tracks the read cycle from select_n and read_strobe_n
// Assumes: Strobes synchronous to clk_i
// Notes:   Start and end pulses, either strobe may control
`timescale 1ns/1ns
module hprp_edge (
	input  wire clk_i,
	input  wire rst_i,
	input  wire select_n_i,
	input  wire read_strobe_n_i,
	output wire active_o,
	output wire start_o,
	output wire end_o
);
	reg act_q;

	// Cycle active while both strobes are low
	assign active_o = ~select_n_i & ~read_strobe_n_i;
	assign start_o  = active_o & ~act_q;
	assign end_o    = ~active_o & act_q;

	// Previous state of the cycle
	always @(posedge clk_i) begin
		if (rst_i)
			act_q <= 1'b0;
		else
			act_q <= active_o;
	end
endmodule // hprp_edge

// File: hprp_read_port.v
// Purpose: Read side of the 16-bit strobe-driven host port
// Assumes: Host pins synchronous to clk_i; FIFOs and counter
//          live outside; FIFOs offer a word with a pop strobe, the counter a count with a clear strobe
// Notes:   Data bus is split into out and enable; no write path
`timescale 1ns/1ns
`include "hprp_defines.vh"

// Notes on behaviour
// RULE1 - Host waits 135 ns or three dummy reads before level reads.
// RULE2 - Host waits 180 ns or four dummy reads between drop reads.
// RULE3 - Test register reads have no side effect, usable as dummies.
// RULE4 - Counter snapshot taken at cycle start, held whole cycle.
// RULE5 - Cycle needs both strobes low, ends when either rises.
// RULE6 - Host raises a strobe between single cycles for a while.
// RULE7 - Serve registers, rx data, rx and tx status by address.
// RULE8 - Burst of up to 16 words, fresh data per address.
// RULE9 - Either strobe may be the controlling one.
// RULE10 - FIFO select high forces rx data FIFO reads.
// RULE11 - In FIFO select mode, A[2:1] decoded, A[7:3] ignored; a mid-cycle change of A[7:3] still pops a word.
// RULE12 - Direct FIFO bursts are unbounded in length.
// RULE13 - FIFO select sampled exactly like an address line.
// RULE14 - Each read moves one 16-bit word.
// RULE15 - Data bus driven only during an active cycle.
// RULE16 - FIFO pop once per completed cycle, at its end; code also pops at each burst address change.
module hprp_read_port #(
	parameter DATA_W    = `HPRP_DATA_W,
	parameter ADDR_W    = `HPRP_ADDR_W,
	parameter CNT_W     = `HPRP_CNT_W,
	parameter BURST_MAX = `HPRP_BURST_MAX
) (
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire              select_n_i,
	input  wire              read_strobe_n_i,
	input  wire              fifo_select_i,
	input  wire [ADDR_W-1:0] addr_i,
	output reg  [DATA_W-1:0] data_o,
	output wire [DATA_W-1:0] data_oe_o,
	input  wire [DATA_W-1:0] rx_data_word_i,
	input  wire [DATA_W-1:0] rx_status_word_i,
	input  wire [DATA_W-1:0] tx_status_word_i,
	input  wire [DATA_W-1:0] rx_fifo_level_info_i,
	input  wire [DATA_W-1:0] tx_fifo_level_info_i,
	input  wire [CNT_W-1:0]  drop_count_i,
	output reg               rx_data_pop_o,
	output reg               rx_status_pop_o,
	output reg               tx_status_pop_o,
	output reg               drop_count_clr_o,
	output wire              burst_overrun_o
);
	// Host-gap figures in core cycles, rounded up
	localparam LEVEL_GAP_CYC =
		(`HPRP_GAP_LEVEL_NS + `HPRP_CLK_NS - 1) / `HPRP_CLK_NS;
	localparam DROP_GAP_CYC =
		(`HPRP_GAP_DROP_NS + `HPRP_CLK_NS - 1) / `HPRP_CLK_NS;

	wire              cyc_active;
	wire              cyc_start;
	wire              cyc_end;
	wire [6:0]        word_ofs;
	wire [1:0]        tgt_now;
	reg  [1:0]        tgt_q;
	reg  [CNT_W-1:0]  drop_snap_q;
	reg               drop_read_q;
	reg               oe_q;
	reg  [ADDR_W-1:0] addr_last_q;
	reg  [4:0]        words_q;
	reg               overrun_q;
	reg  [DATA_W-1:0] rd_d;

	// Target decode of one word offset under the select mode
	function [1:0] hprp_target;
		input [6:0] ofs;
		input       fsel;
		begin
			if (fsel)
				hprp_target = `HPRP_TGT_RXDATA;
			else if (ofs == `HPRP_OFS_RXDATA)
				hprp_target = `HPRP_TGT_RXDATA;
			else if (ofs == `HPRP_OFS_RXSTS)
				hprp_target = `HPRP_TGT_RXSTS;
			else if (ofs == `HPRP_OFS_TXSTS)
				hprp_target = `HPRP_TGT_TXSTS;
			else
				hprp_target = `HPRP_TGT_CSR;
		end
	endfunction

	// RULE5 cycle tracking
	// RULE9 either strobe controls
	hprp_edge i_hprp_edge (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.select_n_i      (select_n_i),
		.read_strobe_n_i (read_strobe_n_i),
		.active_o        (cyc_active),
		.start_o         (cyc_start),
		.end_o           (cyc_end)
	);

	// RULE13 select sampled as address
	// RULE11 lower lanes kept in FIFO mode
	assign word_ofs = fifo_select_i ?
		{5'h00, addr_i[`HPRP_LANE_HI:`HPRP_ADDR_LO]} :
		addr_i[`HPRP_ADDR_HI:`HPRP_ADDR_LO];
	// RULE10 FIFO select forces rx data
	assign tgt_now = hprp_target(word_ofs, fifo_select_i);

	// RULE4 counter snapshot at start
	always @(posedge clk_i) begin
		if (rst_i)
			drop_snap_q <= {CNT_W{1'b0}};
		else if (cyc_start)
			drop_snap_q <= drop_count_i;
	end

	// RULE7 read mux by address
	// RULE14 one 16-bit word per read
	always @* begin
		rd_d = `HPRP_UNMAPPED_VAL;
		case (tgt_now)
			`HPRP_TGT_RXDATA: rd_d = rx_data_word_i;
			`HPRP_TGT_RXSTS:  rd_d = rx_status_word_i;
			`HPRP_TGT_TXSTS:  rd_d = tx_status_word_i;
			default: begin
				case (word_ofs)
					`HPRP_OFS_BYTETEST: rd_d = `HPRP_BYTETEST_VAL;
					`HPRP_OFS_RXLEVEL:  rd_d = rx_fifo_level_info_i;
					`HPRP_OFS_TXLEVEL:  rd_d = tx_fifo_level_info_i;
					`HPRP_OFS_DROP_LO:
						rd_d = cyc_start ? drop_count_i[DATA_W-1:0]
							: drop_snap_q[DATA_W-1:0];
					`HPRP_OFS_DROP_HI:
						rd_d = cyc_start ?
							drop_count_i[CNT_W-1:CNT_W-DATA_W]
							: drop_snap_q[CNT_W-1:CNT_W-DATA_W];
					default: rd_d = `HPRP_UNMAPPED_VAL;
				endcase
			end
		endcase
	end

	// RULE8 data follows each new address
	// RULE12 no length limit in FIFO mode
	always @(posedge clk_i) begin
		if (rst_i)
			data_o <= {DATA_W{1'b0}};
		else if (cyc_active)
			data_o <= rd_d;
	end

	// RULE15 drive only inside a cycle
	always @(posedge clk_i) begin
		if (rst_i)
			oe_q <= 1'b0;
		else
			oe_q <= cyc_active;
	end
	assign data_oe_o = {DATA_W{oe_q & cyc_active}};

	// Target and drop-read flag of the current word
	always @(posedge clk_i) begin
		if (rst_i) begin
			tgt_q       <= `HPRP_TGT_CSR;
			drop_read_q <= 1'b0;
			addr_last_q <= {ADDR_W{1'b0}};
		end else if (cyc_active) begin
			tgt_q       <= tgt_now;
			drop_read_q <= (tgt_now == `HPRP_TGT_CSR) &&
				((word_ofs == `HPRP_OFS_DROP_LO) ||
				 (word_ofs == `HPRP_OFS_DROP_HI));
			addr_last_q <= addr_i;
		end
	end

	// RULE16 pop once per word at its end
	// A burst address change also completes the previous word
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_data_pop_o    <= 1'b0;
			rx_status_pop_o  <= 1'b0;
			tx_status_pop_o  <= 1'b0;
			drop_count_clr_o <= 1'b0;
		end else begin
			rx_data_pop_o    <= 1'b0;
			rx_status_pop_o  <= 1'b0;
			tx_status_pop_o  <= 1'b0;
			drop_count_clr_o <= 1'b0;
			if (cyc_end || (cyc_active && !cyc_start &&
					addr_i != addr_last_q)) begin
				rx_data_pop_o    <= (tgt_q == `HPRP_TGT_RXDATA);
				rx_status_pop_o  <= (tgt_q == `HPRP_TGT_RXSTS);
				tx_status_pop_o  <= (tgt_q == `HPRP_TGT_TXSTS);
				drop_count_clr_o <= drop_read_q;
			end
		end
	end

	// RULE8 count words of a normal burst
	always @(posedge clk_i) begin
		if (rst_i) begin
			words_q   <= 5'h00;
			overrun_q <= 1'b0;
		end else if (!cyc_active) begin
			words_q   <= 5'h00;
		end else if (cyc_start) begin
			words_q   <= 5'h01;
			overrun_q <= 1'b0;
		end else if (addr_i != addr_last_q && !fifo_select_i) begin
			words_q   <= words_q + 5'h01;
			if (words_q >= BURST_MAX[4:0] || words_q == 5'h1f)
				overrun_q <= 1'b1;
		end
	end
	assign burst_overrun_o = overrun_q;

	// RULE1 host keeps LEVEL_GAP_CYC after a pop
	// RULE2 host keeps DROP_GAP_CYC between drop reads
	// RULE3 test register has no side effect
	// RULE6 host gap between single cycles
endmodule // hprp_read_port

// File: hprp_read_port_assertions.sv
// Purpose: Port checker for the host read port
// Assumes: Default widths of the defines
// Notes:   Bound to the top module
`timescale 1ns/1ns
module hprp_chk (
	input wire        clk_i,
	input wire        rst_i,
	input wire        select_n_i,
	input wire        read_strobe_n_i,
	input wire        fifo_select_i,
	input wire [7:0]  addr_i,
	input wire [15:0] data_o,
	input wire [15:0] data_oe_o,
	input wire [15:0] rx_data_word_i,
	input wire        rx_data_pop_o,
	input wire        rx_status_pop_o,
	input wire        tx_status_pop_o
);
	// Cycle term and word offset
	wire       act = !select_n_i && !read_strobe_n_i;
	wire [6:0] ofs = addr_i[7:1];
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_oe_off; !act |-> data_oe_o == 16'h0000; endproperty
	a_oe_off: assert property (p_oe_off) else $error("oe idle");
	property p_oe_on; act && $past(act) |-> data_oe_o == 16'hffff; endproperty
	a_oe_on: assert property (p_oe_on) else $error("oe low");
	property p_fsel;
		act && $past(act) && $past(fifo_select_i)
		|-> data_o == $past(rx_data_word_i);
	endproperty
	a_fsel: assert property (p_fsel) else $error("fifo");
	property p_test;
		act && $past(act) && !$past(fifo_select_i) && $past(ofs) == 7'h32
		|-> data_o == 16'h4321;
	endproperty
	a_test: assert property (p_test) else $error("test");
	property p_snap;
		act && $past(act) && $past(act, 2) && !$past(fifo_select_i)
		&& !$past(fifo_select_i, 2)
		&& $past(ofs) == 7'h50 && $past(ofs, 2) == 7'h50 |-> $stable(data_o);
	endproperty
	a_snap: assert property (p_snap) else $error("snap");
	property p_pop; $fell(act) && $past(fifo_select_i) |=> rx_data_pop_o;
	endproperty
	a_pop: assert property (p_pop) else $error("pop");
	property p_rs_pop;
		$fell(act) && !$past(fifo_select_i) && $past(ofs) == 7'h20
		|=> rx_status_pop_o;
	endproperty
	a_rs_pop: assert property (p_rs_pop) else $error("rs pop");
	property p_idle;
		!act && !$past(act) && !$past(act, 2)
		|-> !(rx_data_pop_o || rx_status_pop_o || tx_status_pop_o);
	endproperty
	a_idle: assert property (p_idle) else $error("idle pop");
	c_burst: cover property (act [*8]);
	c_fsel: cover property ($fell(act) && $past(fifo_select_i));
	c_snap: cover property (act && ofs == 7'h50);
endmodule // hprp_chk

bind hprp_read_port hprp_chk i_chk (.clk_i, .rst_i, .select_n_i,
	.read_strobe_n_i, .fifo_select_i, .addr_i, .data_o, .data_oe_o,
	.rx_data_word_i, .rx_data_pop_o, .rx_status_pop_o, .tx_status_pop_o);

// File: hprp_src_model.sv
// Purpose: FIFO heads and drop counter
// Assumes: Pops are one-clock pulses
// Notes:   Heads count up per pop
`timescale 1ns/1ns
module hprp_src_model (
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        rx_pop_i,
	input  wire        rs_pop_i,
	input  wire        ts_pop_i,
	input  wire        clr_i,
	output reg  [15:0] rx_o,
	output reg  [15:0] rs_o,
	output reg  [15:0] ts_o,
	output reg  [31:0] drop_o
);
	// Next head per pop; counter always runs
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_o <= 16'h1000;
			rs_o <= 16'h2000;
			ts_o <= 16'h3000;
			drop_o <= 32'h0;
		end else begin
			rx_o <= rx_o + rx_pop_i;
			rs_o <= rs_o + rs_pop_i;
			ts_o <= ts_o + ts_pop_i;
			drop_o <= clr_i ? 32'h0 : drop_o + 32'h1;
		end
	end
endmodule // hprp_src_model

// File: test_hprp_read_port.sv
// Purpose: Bench for the host read port
// Assumes: Inputs move on the falling edge
// Notes:   Seeded reads and corner bursts
`timescale 1ns/1ns
`include "hprp_defines.vh"
module test_hprp_read_port;
	// Ring order keeps level and drop reads far from their side effects
	localparam [69:0] OFS = {7'h32, 7'h51, 7'h40, 7'h3e, 7'h60,
		7'h32, 7'h50, 7'h24, 7'h20, 7'h00};
	reg         clk_i = 0, rst_i = 1, select_n_i = 1, read_strobe_n_i = 1;
	reg         fifo_select_i = 0;
	reg  [7:0]  addr_i = 0;
	reg  [31:0] lfsr = 32'h6103c664;
	reg  [31:0] snap = 32'h0;
	wire [15:0] data_o, data_oe_o, rxd, rxs, txs;
	wire [31:0] drop;
	wire        rxp, rsp, tsp, clr, ovr;
	integer     error_cnt = 0, n_compared = 0, rx_n = 0, rs_n = 0;
	integer     ts_n = 0, i, j;

	hprp_read_port i_hprp_read_port (.clk_i, .rst_i, .select_n_i,
		.read_strobe_n_i, .fifo_select_i, .addr_i, .data_o, .data_oe_o,
		.rx_data_word_i(rxd), .rx_status_word_i(rxs),
		.tx_status_word_i(txs), .rx_fifo_level_info_i(16'h0a0a),
		.tx_fifo_level_info_i(16'h0b0b), .drop_count_i(drop),
		.rx_data_pop_o(rxp), .rx_status_pop_o(rsp),
		.tx_status_pop_o(tsp), .drop_count_clr_o(clr), .burst_overrun_o(ovr));
	hprp_src_model i_hprp_src_model (.clk_i, .rst_i, .rx_pop_i(rxp),
		.rs_pop_i(rsp), .ts_pop_i(tsp), .clr_i(clr), .rx_o(rxd),
		.rs_o(rxs), .ts_o(txs), .drop_o(drop));

	initial forever #2 clk_i = ~clk_i;
	function [31:0] nxt(input [31:0] s);
		nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [15:0] exp_of(input f, input [6:0] o);
		if (f || o == 7'h00) exp_of = 16'h1000 + rx_n[15:0];
		else if (o == 7'h20) exp_of = 16'h2000 + rs_n[15:0];
		else if (o == 7'h24) exp_of = 16'h3000 + ts_n[15:0];
		else if (o == 7'h32) exp_of = `HPRP_BYTETEST_VAL;
		else if (o == 7'h3e) exp_of = 16'h0a0a;
		else if (o == 7'h40) exp_of = 16'h0b0b;
		else if (o == 7'h50) exp_of = snap[15:0];
		else if (o == 7'h51) exp_of = snap[31:16];
		else exp_of = `HPRP_UNMAPPED_VAL;
	endfunction
	task check(input [15:0] seen, input [15:0] expd);
		begin
			n_compared = n_compared + 1;
			if (seen !== expd) begin
				error_cnt = error_cnt + 1;
				$display("FAIL %0t read %h not %h", $time, seen, expd);
			end
		end
	endtask
	task conclude;
		begin
			if (error_cnt == 0 && n_compared > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// One cycle of n words starting at table entry k, or stepping A[2:1] when f is set
	task cycle(input f, input integer n, input integer k);
		begin
			lfsr = nxt(lfsr);
			fifo_select_i = f;
			if (lfsr[0]) select_n_i = 0; else read_strobe_n_i = 0;
			for (j = 0; j < n; j = j + 1) begin
				addr_i = f ? {lfsr[7:3], j[1:0], lfsr[8]}
					: {OFS[7*((k+j)%10) +: 7], lfsr[9]};
				@(negedge clk_i);
				select_n_i = 0;
				read_strobe_n_i = 0;
				// counter value that the start edge latches
				if (j == 0) snap = drop;
				// 48 ns per word, longer than a 45 ns dummy read
				repeat (11) @(negedge clk_i);
				check(data_o, exp_of(f, addr_i[7:1]));
				if (f || addr_i[7:1] == 7'h00) rx_n = rx_n + 1;
				else if (addr_i[7:1] == 7'h20) rs_n = rs_n + 1;
				else if (addr_i[7:1] == 7'h24) ts_n = ts_n + 1;
			end
			check({15'h0, ovr}, {15'h0, !f && n > `HPRP_BURST_MAX});
			if (lfsr[1]) select_n_i = 1; else read_strobe_n_i = 1;
			@(negedge clk_i);
			select_n_i = 1;
			read_strobe_n_i = 1;
			repeat (46) @(negedge clk_i);
		end
	endtask
	// Reset, all targets, full bursts, then random reads
	initial begin
		repeat (10) @(negedge clk_i);
		rst_i = 0;
		@(negedge clk_i);
		for (i = 0; i < 10; i = i + 1) cycle(0, 1, i);
		cycle(0, 16, 0);
		cycle(1, 24, 0);
		cycle(0, 17, 3);
		// Reset in mid-run clears overrun, data and enable
		rst_i = 1;
		repeat (2) @(negedge clk_i);
		check(data_o, 16'h0000);
		check(data_oe_o, 16'h0000);
		check({15'h0, ovr}, 16'h0000);
		rst_i = 0;
		rx_n = 0;
		rs_n = 0;
		ts_n = 0;
		@(negedge clk_i);
		for (i = 0; i < 150; i = i + 1) begin
			lfsr = nxt(lfsr);
			cycle(lfsr[2], lfsr[6:3] + 1, lfsr[12:10]);
		end
		conclude;
	end
	// Watchdog
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		conclude;
	end
endmodule // test_hprp_read_port
